// ### hw/bbc_pkg.sv
// Package: register map, field layout and encodings of the channel B break comparator
package bbc_pkg;

  // ****************************************************************
  // Register bus
  // ****************************************************************
  localparam int unsigned REG_ADDR_W = 8;
  localparam int unsigned REG_DATA_W = 32;
  typedef logic [REG_ADDR_W-1:0] bbc_addr_t;
  typedef logic [REG_DATA_W-1:0] bbc_word_t;

  localparam bbc_addr_t OFS_BREAK_ADDR = 8'h00;
  localparam bbc_addr_t OFS_ADDR_MASK = 8'h04;
  localparam bbc_addr_t OFS_BREAK_DATA = 8'h08;
  localparam bbc_addr_t OFS_DATA_MASK = 8'h0C;
  localparam bbc_addr_t OFS_BUS_CYCLE = 8'h10;
  localparam bbc_addr_t OFS_REPEAT_CTRL = 8'h14;
  localparam bbc_addr_t OFS_REPEAT_LIVE = 8'h18;
  localparam bbc_addr_t OFS_IRQ_STATUS = 8'h1C;
  localparam bbc_addr_t OFS_IRQ_MASK = 8'h20;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam bbc_word_t WORD_RST = 32'h0000_0000;
  localparam bbc_word_t WORD_ZERO = 32'h0000_0000;

  // ****************************************************************
  // Bus cycle select layout
  // ****************************************************************
  localparam int unsigned CYC_SEL_W = 8;
  typedef logic [CYC_SEL_W-1:0] bbc_cyc_t;
  localparam bbc_cyc_t CYC_SEL_RST = 8'h00;
  localparam int unsigned MASTER_HI = 7;
  localparam int unsigned MASTER_LO = 6;
  localparam int unsigned TYPE_HI = 5;
  localparam int unsigned TYPE_LO = 4;
  localparam int unsigned DIR_HI = 3;
  localparam int unsigned DIR_LO = 2;
  localparam int unsigned SIZE_HI = 1;
  localparam int unsigned SIZE_LO = 0;

  localparam logic [1:0] SEL_OFF = 2'h0;
  localparam logic [1:0] MASTER_DMA = 2'h2;
  localparam logic [1:0] SIZE_ANY = 2'h0;
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] SIZE_LONG = 2'h3;

  // Byte lanes for byte-size data compare
  localparam bbc_word_t LANE_EVEN_MASK = 32'h0000_FF00;
  localparam bbc_word_t LANE_ODD_MASK = 32'h0000_00FF;
  localparam bbc_word_t LANE_ALL_MASK = 32'hFFFF_FFFF;

  // ****************************************************************
  // Repeat count and interrupt layout
  // ****************************************************************
  localparam int unsigned RPT_CNT_W = 12;
  typedef logic [RPT_CNT_W-1:0] bbc_rpt_t;
  localparam bbc_rpt_t RPT_RST = 12'h000;
  localparam bbc_rpt_t RPT_ONE = 12'h001;
  localparam int unsigned RPT_EN_BIT = 16;

  localparam int unsigned IRQ_W = 2;
  typedef logic [IRQ_W-1:0] bbc_irq_t;
  localparam bbc_irq_t IRQ_RST = 2'h0;
  localparam int unsigned IRQ_MATCH_BIT = 0;
  localparam int unsigned IRQ_BREAK_BIT = 1;

endpackage : bbc_pkg

// ### hw/bbc_match.sv
// Combinational compare of one monitored bus cycle against channel B conditions
`timescale 1ns/10ps
`default_nettype none

module bbc_match (
  input wire logic [31:0] break_addr,
  input wire logic [31:0] addr_mask,
  input wire logic [31:0] break_data,
  input wire logic [31:0] data_mask,
  input wire logic [7:0] cycle_sel,
  input wire logic data_cmp_en,
  input wire logic bus_valid,
  input wire logic bus_is_dma,
  input wire logic bus_is_fetch,
  input wire logic bus_is_write,
  input wire logic [1:0] bus_size,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_data,
  output logic cond_hit
);

  logic [1:0] master_sel;
  logic [1:0] type_sel;
  logic [1:0] dir_sel;
  logic [1:0] size_sel;
  logic [31:0] lane_mask;
  logic [31:0] data_cmp_mask;
  logic [31:0] addr_bit_ok;
  logic [31:0] data_bit_ok;
  logic addr_ok;
  logic data_ok;
  logic master_ok;
  logic type_ok;
  logic dir_ok;
  logic size_ok;

  assign master_sel = cycle_sel[bbc_pkg::MASTER_HI:bbc_pkg::MASTER_LO];
  assign type_sel = cycle_sel[bbc_pkg::TYPE_HI:bbc_pkg::TYPE_LO];
  assign dir_sel = cycle_sel[bbc_pkg::DIR_HI:bbc_pkg::DIR_LO];
  assign size_sel = cycle_sel[bbc_pkg::SIZE_HI:bbc_pkg::SIZE_LO];

  // ****************************************************************
  // Per-bit masked compare
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_bit
      // Mask bit one drops the bit from the compare
      assign addr_bit_ok[gi] = addr_mask[gi] | (bus_addr[gi] == break_addr[gi]);
      assign data_bit_ok[gi] = ~data_cmp_mask[gi] | (bus_data[gi] == break_data[gi]);
    end
  endgenerate

  // Byte compare uses the lane picked by the break address parity
  always_comb begin
    if (size_sel == bbc_pkg::SIZE_BYTE) begin
      lane_mask = break_addr[0] ? bbc_pkg::LANE_ODD_MASK : bbc_pkg::LANE_EVEN_MASK;
    end else begin
      lane_mask = bbc_pkg::LANE_ALL_MASK;
    end
    data_cmp_mask = ~data_mask & lane_mask;
  end

  assign addr_ok = &addr_bit_ok;
  assign data_ok = !data_cmp_en || (&data_bit_ok);

  // ****************************************************************
  // Cycle attribute selects
  // ****************************************************************
  always_comb begin
    // X1 is CPU, 10 is DMA, 00 never matches
    if (master_sel[0]) begin
      master_ok = !bus_is_dma;
    end else begin
      master_ok = (master_sel == bbc_pkg::MASTER_DMA) && bus_is_dma;
    end
    type_ok = bus_is_fetch ? type_sel[0] : type_sel[1];
    dir_ok = bus_is_write ? dir_sel[1] : dir_sel[0];
    size_ok = (size_sel == bbc_pkg::SIZE_ANY) || (size_sel == bus_size);
  end

  // All enabled sub-conditions in the same cycle
  assign cond_hit = bus_valid && addr_ok && data_ok && master_ok && type_ok
                    && dir_ok && size_ok;

endmodule : bbc_match

`default_nettype wire

// ### hw/bbc_chan_b.sv
// Channel B break comparator: registers, repeat counter, interrupt and match outputs
//
// Behaviour
// - Compare the 32-bit bus address against the break address register.
// - Address mask bit one excludes that address bit; zero includes it.
// - Break data register is 32 bits, readable and writable.
// - Data mask bit zero includes that data bit; one ignores it.
// - Byte data break: even address uses bits 15 to 8, odd 7 to 0.
// - Bus cycle select bits 15 to 8 are reserved and read zero.
// - Master field: 00 off, X1 CPU, 10 DMA.
// - Type field: 00 off, 01 fetch, 10 data, 11 either.
// - Direction field: 00 off, 01 read, 10 write, 11 either.
// - Size field: 00 any, 01 byte, 10 word, 11 longword.
// - Data compare enable comes from outside these registers.
// - Optional repeat count must be reached before a break is taken.
`timescale 1ns/10ps
`default_nettype none

module bbc_chan_b (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire logic data_cmp_en,
  input wire logic bus_valid,
  input wire logic bus_is_dma,
  input wire logic bus_is_fetch,
  input wire logic bus_is_write,
  input wire logic [1:0] bus_size,
  input wire logic [31:0] instr_address_bus,
  input wire logic [31:0] data_address_bus,
  input wire logic [31:0] data_bus,
  output logic match_pulse,
  output logic break_pulse,
  output logic irq
);

  // ****************************************************************
  // Condition registers
  // ****************************************************************
  logic [31:0] break_addr_reg;
  logic [31:0] break_addr_next;
  logic [31:0] addr_mask_reg;
  logic [31:0] addr_mask_next;
  logic [31:0] break_data_reg;
  logic [31:0] break_data_next;
  logic [31:0] data_mask_reg;
  logic [31:0] data_mask_next;
  logic [7:0] cycle_sel_reg;
  logic [7:0] cycle_sel_next;

  // ****************************************************************
  // Repeat and interrupt state
  // ****************************************************************
  logic rpt_en_reg;
  logic rpt_en_next;
  logic [11:0] rpt_limit_reg;
  logic [11:0] rpt_limit_next;
  logic [11:0] rpt_hits_reg;
  logic [11:0] rpt_hits_next;
  logic [1:0] irq_status_reg;
  logic [1:0] irq_status_next;
  logic [1:0] irq_mask_reg;
  logic [1:0] irq_mask_next;
  logic match_reg;
  logic match_next;
  logic break_reg;
  logic break_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  logic [31:0] bus_addr;
  logic cond_hit;
  logic [11:0] hits_plus;
  logic take_break;
  logic [1:0] irq_events;
  logic [1:0] irq_clear;

  // ****************************************************************
  // Address source and comparator
  // ****************************************************************
  // Fetches drive the instruction address bus, data cycles the other
  assign bus_addr = bus_is_fetch ? instr_address_bus : data_address_bus;

  bbc_match u_match (
    .break_addr(break_addr_reg),
    .addr_mask(addr_mask_reg),
    .break_data(break_data_reg),
    .data_mask(data_mask_reg),
    .cycle_sel(cycle_sel_reg),
    .data_cmp_en(data_cmp_en),
    .bus_valid(bus_valid),
    .bus_is_dma(bus_is_dma),
    .bus_is_fetch(bus_is_fetch),
    .bus_is_write(bus_is_write),
    .bus_size(bus_size),
    .bus_addr(bus_addr),
    .bus_data(data_bus),
    .cond_hit(cond_hit)
  );

  // ****************************************************************
  // Register writes
  // ****************************************************************
  always_comb begin
    break_addr_next = break_addr_reg;
    addr_mask_next = addr_mask_reg;
    break_data_next = break_data_reg;
    data_mask_next = data_mask_reg;
    cycle_sel_next = cycle_sel_reg;
    rpt_en_next = rpt_en_reg;
    rpt_limit_next = rpt_limit_reg;
    irq_mask_next = irq_mask_reg;
    irq_clear = bbc_pkg::IRQ_RST;
    if (reg_write) begin
      unique case (reg_addr)
        bbc_pkg::OFS_BREAK_ADDR: begin
          break_addr_next = reg_wdata;
        end
        bbc_pkg::OFS_ADDR_MASK: begin
          addr_mask_next = reg_wdata;
        end
        bbc_pkg::OFS_BREAK_DATA: begin
          break_data_next = reg_wdata;
        end
        bbc_pkg::OFS_DATA_MASK: begin
          data_mask_next = reg_wdata;
        end
        bbc_pkg::OFS_BUS_CYCLE: begin
          // Reserved upper byte is not stored
          cycle_sel_next = reg_wdata[bbc_pkg::CYC_SEL_W-1:0];
        end
        bbc_pkg::OFS_REPEAT_CTRL: begin
          rpt_en_next = reg_wdata[bbc_pkg::RPT_EN_BIT];
          rpt_limit_next = reg_wdata[bbc_pkg::RPT_CNT_W-1:0];
        end
        bbc_pkg::OFS_IRQ_STATUS: begin
          // Writing one clears that sticky bit
          irq_clear = reg_wdata[bbc_pkg::IRQ_W-1:0];
        end
        bbc_pkg::OFS_IRQ_MASK: begin
          irq_mask_next = reg_wdata[bbc_pkg::IRQ_W-1:0];
        end
        // Unmapped and read-only offsets ignore writes
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // Repeat counter and outputs
  // ****************************************************************
  assign hits_plus = rpt_hits_reg + bbc_pkg::RPT_ONE;

  always_comb begin
    rpt_hits_next = rpt_hits_reg;
    take_break = 1'b0;
    if (cond_hit) begin
      // Break on the match that brings the count to the limit
      // Limit of zero or one breaks on every match
      if (!rpt_en_reg || (hits_plus >= rpt_limit_reg)) begin
        take_break = 1'b1;
        rpt_hits_next = bbc_pkg::RPT_RST;
      end else begin
        rpt_hits_next = hits_plus;
      end
    end
    // Reprogramming the repeat control restarts the count
    // A match in that same cycle is not counted
    if (reg_write && (reg_addr == bbc_pkg::OFS_REPEAT_CTRL)) begin
      rpt_hits_next = bbc_pkg::RPT_RST;
    end
    match_next = cond_hit;
    break_next = take_break;
  end

  // ****************************************************************
  // Interrupt status
  // ****************************************************************
  always_comb begin
    irq_events = bbc_pkg::IRQ_RST;
    irq_events[bbc_pkg::IRQ_MATCH_BIT] = cond_hit;
    irq_events[bbc_pkg::IRQ_BREAK_BIT] = take_break;
    // New event wins over a clear in the same cycle
    irq_status_next = (irq_status_reg & ~irq_clear) | irq_events;
  end

  // ****************************************************************
  // Read data, one cycle after the read strobe
  // ****************************************************************
  always_comb begin
    // Idle and unmapped reads return zero
    rdata_next = bbc_pkg::WORD_ZERO;
    if (reg_read) begin
      unique case (reg_addr)
        bbc_pkg::OFS_BREAK_ADDR: begin
          rdata_next = break_addr_reg;
        end
        bbc_pkg::OFS_ADDR_MASK: begin
          rdata_next = addr_mask_reg;
        end
        bbc_pkg::OFS_BREAK_DATA: begin
          rdata_next = break_data_reg;
        end
        bbc_pkg::OFS_DATA_MASK: begin
          rdata_next = data_mask_reg;
        end
        bbc_pkg::OFS_BUS_CYCLE: begin
          rdata_next[bbc_pkg::CYC_SEL_W-1:0] = cycle_sel_reg;
        end
        bbc_pkg::OFS_REPEAT_CTRL: begin
          rdata_next[bbc_pkg::RPT_EN_BIT] = rpt_en_reg;
          rdata_next[bbc_pkg::RPT_CNT_W-1:0] = rpt_limit_reg;
        end
        bbc_pkg::OFS_REPEAT_LIVE: begin
          rdata_next[bbc_pkg::RPT_CNT_W-1:0] = rpt_hits_reg;
        end
        bbc_pkg::OFS_IRQ_STATUS: begin
          rdata_next[bbc_pkg::IRQ_W-1:0] = irq_status_reg;
        end
        bbc_pkg::OFS_IRQ_MASK: begin
          rdata_next[bbc_pkg::IRQ_W-1:0] = irq_mask_reg;
        end
        default: begin
          rdata_next = bbc_pkg::WORD_ZERO;
        end
      endcase
    end
  end

  // ****************************************************************
  // State registers
  // ****************************************************************
  // Software-written registers
  always_ff @(posedge clock) begin
    if (rst) begin
      break_addr_reg <= bbc_pkg::WORD_RST;
      addr_mask_reg <= bbc_pkg::WORD_RST;
      break_data_reg <= bbc_pkg::WORD_RST;
      data_mask_reg <= bbc_pkg::WORD_RST;
      cycle_sel_reg <= bbc_pkg::CYC_SEL_RST;
      rpt_en_reg <= 1'b0;
      rpt_limit_reg <= bbc_pkg::RPT_RST;
      irq_mask_reg <= bbc_pkg::IRQ_RST;
    end else begin
      break_addr_reg <= break_addr_next;
      addr_mask_reg <= addr_mask_next;
      break_data_reg <= break_data_next;
      data_mask_reg <= data_mask_next;
      cycle_sel_reg <= cycle_sel_next;
      rpt_en_reg <= rpt_en_next;
      rpt_limit_reg <= rpt_limit_next;
      irq_mask_reg <= irq_mask_next;
    end
  end

  // Repeat count and match pulses
  always_ff @(posedge clock) begin
    if (rst) begin
      rpt_hits_reg <= bbc_pkg::RPT_RST;
      match_reg <= 1'b0;
      break_reg <= 1'b0;
    end else begin
      rpt_hits_reg <= rpt_hits_next;
      match_reg <= match_next;
      break_reg <= break_next;
    end
  end

  // Sticky interrupt status
  always_ff @(posedge clock) begin
    if (rst) begin
      irq_status_reg <= bbc_pkg::IRQ_RST;
    end else begin
      irq_status_reg <= irq_status_next;
    end
  end

  // Read data register
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_reg <= bbc_pkg::WORD_RST;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign match_pulse = match_reg;
  assign break_pulse = break_reg;
  // Level output while an unmasked sticky bit is set
  assign irq = |(irq_status_reg & irq_mask_reg);

endmodule : bbc_chan_b

`default_nettype wire

// ### testbench/bbc_chan_b_checker.sv
// Checker: port properties of the channel B break comparator
`timescale 1ns/10ps
`default_nettype none

module bbc_chan_b_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic data_cmp_en,
  input wire logic bus_valid,
  input wire logic bus_is_dma,
  input wire logic bus_is_fetch,
  input wire logic bus_is_write,
  input wire logic [1:0] bus_size,
  input wire logic [31:0] instr_address_bus,
  input wire logic [31:0] data_address_bus,
  input wire logic [31:0] data_bus,
  input wire logic match_pulse,
  input wire logic break_pulse,
  input wire logic irq
);
  // ****************************************************************
  // Shadow registers and sub-conditions
  // ****************************************************************
  logic [31:0] ba, am, bd, dm, lane, a_bus;
  logic [7:0] cs;
  logic addr_ok, data_ok, mst_ok, typ_ok, dir_ok, siz_ok;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  always_ff @(posedge clock) begin
    if (rst) begin
      ba <= '0;
      am <= '0;
      bd <= '0;
      dm <= '0;
      cs <= '0;
    end else if (reg_write) begin
      case (reg_addr)
        bbc_pkg::OFS_BREAK_ADDR: ba <= reg_wdata;
        bbc_pkg::OFS_ADDR_MASK: am <= reg_wdata;
        bbc_pkg::OFS_BREAK_DATA: bd <= reg_wdata;
        bbc_pkg::OFS_DATA_MASK: dm <= reg_wdata;
        bbc_pkg::OFS_BUS_CYCLE: cs <= reg_wdata[7:0];
        default: ;
      endcase
    end
  end
  assign lane = (cs[1:0] != 2'h1) ? 32'hFFFF_FFFF : ba[0] ? 32'h0000_00FF : 32'h0000_FF00;
  assign a_bus = bus_is_fetch ? instr_address_bus : data_address_bus;
  assign addr_ok = ((a_bus ^ ba) & ~am) == 32'h0000_0000;
  assign data_ok = !data_cmp_en || (((data_bus ^ bd) & ~dm & lane) == 32'h0000_0000);
  assign mst_ok = cs[6] ? !bus_is_dma : (cs[7] && bus_is_dma);
  assign typ_ok = bus_is_fetch ? cs[4] : cs[5];
  assign dir_ok = bus_is_write ? cs[3] : cs[2];
  assign siz_ok = (cs[1:0] == 2'h0) || (cs[1:0] == bus_size);
  // ****************************************************************
  // Properties
  // ****************************************************************
  AST_RDATA_IDLE: assert property (!reg_read |=> reg_rdata == 32'h0000_0000)
    else $error("Read data not zero outside a read");
  AST_RESERVED_ZERO: assert property (
    reg_read && reg_addr == bbc_pkg::OFS_BUS_CYCLE |=> reg_rdata[31:8] == 24'h00_0000)
    else $error("Reserved bus cycle bits not zero");
  AST_DATA_READBACK: assert property (
    reg_read && reg_addr == bbc_pkg::OFS_BREAK_DATA |=> reg_rdata == bd)
    else $error("Break data readback wrong");
  AST_ADDR_CMP: assert property (bus_valid && !addr_ok |=> !match_pulse)
    else $error("Match despite address mismatch");
  AST_DATA_CMP: assert property (bus_valid && !data_ok |=> !match_pulse)
    else $error("Match despite data mismatch");
  AST_MASTER_SEL: assert property (bus_valid && !mst_ok |=> !match_pulse)
    else $error("Match despite master mismatch");
  AST_TYPE_SEL: assert property (bus_valid && !typ_ok |=> !match_pulse)
    else $error("Match despite cycle type mismatch");
  AST_DIR_SEL: assert property (bus_valid && !dir_ok |=> !match_pulse)
    else $error("Match despite direction mismatch");
  AST_SIZE_SEL: assert property (bus_valid && !siz_ok |=> !match_pulse)
    else $error("Match despite size mismatch");
  AST_FULL_MATCH: assert property (
    bus_valid && addr_ok && data_ok && mst_ok && typ_ok && dir_ok && siz_ok |=> match_pulse)
    else $error("Missing match");
  AST_IDLE_NO_MATCH: assert property (!bus_valid |=> !match_pulse)
    else $error("Match without bus cycle");
  AST_BREAK_WITH_MATCH: assert property (break_pulse |-> match_pulse)
    else $error("Break without match");
  cover property (match_pulse && !break_pulse);
  cover property (break_pulse);
  cover property (irq);
endmodule : bbc_chan_b_checker

bind bbc_chan_b bbc_chan_b_checker i_bbc_chan_b_checker (.clock, .rst, .reg_addr, .reg_wdata,
  .reg_write, .reg_read, .reg_rdata, .data_cmp_en, .bus_valid, .bus_is_dma, .bus_is_fetch,
  .bus_is_write, .bus_size, .instr_address_bus, .data_address_bus, .data_bus, .match_pulse,
  .break_pulse, .irq);

`default_nettype wire

// ### testbench/bbc_bus_model.sv
// Model of the CPU and DMA buses watched by the comparator
`timescale 1ns/10ps
`default_nettype none

module bbc_bus_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic go,
  input wire logic dma,
  input wire logic fetch,
  input wire logic write,
  input wire logic [1:0] size,
  input wire logic [31:0] addr,
  input wire logic [31:0] data,
  output logic bus_valid,
  output logic bus_is_dma,
  output logic bus_is_fetch,
  output logic bus_is_write,
  output logic [1:0] bus_size,
  output logic [31:0] instr_address_bus,
  output logic [31:0] data_address_bus,
  output logic [31:0] data_bus
);
  // Released lines other than bus_valid show the inverse of their last value; bus_valid drops to zero
  always_ff @(posedge clock) begin
    if (rst) begin
      bus_valid <= 1'b0;
      bus_is_dma <= 1'b0;
      bus_is_fetch <= 1'b0;
      bus_is_write <= 1'b0;
      bus_size <= 2'h0;
      instr_address_bus <= '0;
      data_address_bus <= '0;
      data_bus <= '0;
    end else begin
      bus_valid <= go;
      bus_is_dma <= go ? dma : ~bus_is_dma;
      bus_is_fetch <= go ? fetch : ~bus_is_fetch;
      bus_is_write <= go ? write : ~bus_is_write;
      bus_size <= go ? size : ~bus_size;
      instr_address_bus <= (go && fetch) ? addr : ~instr_address_bus;
      data_address_bus <= (go && !fetch) ? addr : ~data_address_bus;
      data_bus <= go ? data : ~data_bus;
    end
  end
endmodule : bbc_bus_model

`default_nettype wire

// ### testbench/bbc_chan_b_bench.sv
// Self-checking bench for the channel B break comparator
`timescale 1ns/10ps
`default_nettype none

module bbc_chan_b_bench;
  logic clock, rst, reg_write, reg_read, data_cmp_en, bus_valid, bus_is_dma, bus_is_fetch;
  logic bus_is_write, match_pulse, break_pulse, irq, go, g_dma, g_fetch, g_write;
  logic dma, fetch, wr, en, hit;
  logic [1:0] bus_size, g_size, sz;
  logic [7:0] reg_addr, cs;
  logic [31:0] reg_wdata, reg_rdata, instr_address_bus, data_address_bus, data_bus;
  logic [31:0] g_addr, g_data, ba, am, bd, dm, ga, gd, r, q;
  logic [31:0] seed = 32'hf594_7397;
  int bad_count = 0;
  int compares = 0;
  bbc_chan_b i_bbc_chan_b (.clock, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .data_cmp_en, .bus_valid, .bus_is_dma, .bus_is_fetch, .bus_is_write, .bus_size,
    .instr_address_bus, .data_address_bus, .data_bus, .match_pulse, .break_pulse, .irq);
  bbc_bus_model i_bbc_bus_model (.clock, .rst, .go, .dma(g_dma), .fetch(g_fetch),
    .write(g_write), .size(g_size), .addr(g_addr), .data(g_data), .bus_valid, .bus_is_dma,
    .bus_is_fetch, .bus_is_write, .bus_size, .instr_address_bus, .data_address_bus, .data_bus);
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd
  function automatic logic exp_hit();
    logic [31:0] lane;
    lane = (cs[1:0] != 2'h1) ? 32'hFFFF_FFFF : ba[0] ? 32'h0000_00FF : 32'h0000_FF00;
    return (((ga ^ ba) & ~am) == 32'h0000_0000) && (cs[6] ? !dma : (cs[7] && dma))
      && (!en || (((gd ^ bd) & ~dm & lane) == 32'h0000_0000))
      && (fetch ? cs[4] : cs[5]) && (wr ? cs[3] : cs[2])
      && ((cs[1:0] == 2'h0) || (cs[1:0] == sz));
  endfunction : exp_hit
  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t word %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    @(posedge clock);
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    chk_word(reg_rdata, exp);
    @(posedge clock);
  endtask : rd_reg
  task automatic cyc(input logic em, input logic eb);
    {g_dma, g_fetch, g_write, g_size} <= {dma, fetch, wr, sz};
    g_addr <= ga;
    g_data <= gd;
    data_cmp_en <= en;
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    @(posedge clock);
    #1;
    chk_bit(match_pulse, em);
    chk_bit(break_pulse, eb);
    @(posedge clock);
  endtask : cyc
  task automatic complete_run();
    $display("Mismatches %0d, compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run
  // ****************************************************************
  // Stimulus
  // ****************************************************************
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial begin
    #1_000_000;
    bad_count++;
    complete_run();
  end
  initial begin
    {rst, reg_write, reg_read, data_cmp_en, go, g_dma, g_fetch, g_write} = 8'h80;
    {reg_addr, reg_wdata, g_size, g_addr, g_data} = '0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    for (int i = 0; i < 10; i++) rd_reg(8'(4 * i), 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      wr_reg(8'(4 * i), r);
      rd_reg(8'(4 * i), r);
    end
    wr_reg(bbc_pkg::OFS_BUS_CYCLE, 32'hFFFF_FFFF);
    rd_reg(bbc_pkg::OFS_BUS_CYCLE, 32'h0000_00FF);
    wr_reg(8'h24, 32'hFFFF_FFFF);
    rd_reg(8'h24, 32'h0000_0000);
    for (int i = 0; i < 200; i++) begin
      r = rnd();
      q = rnd();
      ba = rnd();
      am = rnd() & rnd();
      bd = rnd();
      dm = rnd() & rnd() & rnd();
      {dma, fetch, wr, en} = {r[11], r[12], r[13], r[8]};
      sz = (r[10:9] == 2'h0) ? 2'h3 : r[10:9];
      cs = {dma ? 2'h2 : {r[14], 1'b1}, fetch ? {r[15], 1'b1} : {1'b1, r[15]},
        wr ? {r[16], 1'b1} : {1'b1, r[16]}, r[17] ? sz : 2'h0};
      if (r[20:18] == 3'h0) cs = cs ^ (8'h01 << r[23:21]);
      if (en && cs[1:0] == 2'h0) cs[1:0] = sz;
      ga = ba ^ (q & am) ^ ((r[25:24] == 2'h0) ? (32'h0000_0001 << r[30:26]) : 32'h0000_0000);
      gd = bd ^ (rnd() & dm) ^ (r[31] ? (32'h0000_0001 << q[4:0]) : 32'h0000_0000);
      hit = exp_hit();
      wr_reg(bbc_pkg::OFS_BREAK_ADDR, ba);
      wr_reg(bbc_pkg::OFS_ADDR_MASK, am);
      wr_reg(bbc_pkg::OFS_BREAK_DATA, bd);
      wr_reg(bbc_pkg::OFS_DATA_MASK, dm);
      wr_reg(bbc_pkg::OFS_BUS_CYCLE, {24'h00_0000, cs});
      cyc(hit, hit);
    end
    // Interrupt raise, mask and clear
    {dma, en} = 2'h0;
    wr_reg(bbc_pkg::OFS_ADDR_MASK, 32'hFFFF_FFFF);
    wr_reg(bbc_pkg::OFS_BUS_CYCLE, 32'h0000_007C);
    wr_reg(bbc_pkg::OFS_IRQ_STATUS, 32'h0000_0003);
    chk_bit(irq, 1'b0);
    cyc(1'b1, 1'b1);
    chk_bit(irq, 1'b0);
    rd_reg(bbc_pkg::OFS_IRQ_STATUS, 32'h0000_0003);
    wr_reg(bbc_pkg::OFS_IRQ_MASK, 32'h0000_0001);
    chk_bit(irq, 1'b1);
    wr_reg(bbc_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
    chk_bit(irq, 1'b0);
    rd_reg(bbc_pkg::OFS_IRQ_STATUS, 32'h0000_0002);
    wr_reg(bbc_pkg::OFS_IRQ_MASK, 32'h0000_0003);
    chk_bit(irq, 1'b1);
    wr_reg(bbc_pkg::OFS_IRQ_STATUS, 32'h0000_0002);
    chk_bit(irq, 1'b0);
    // Repeat count of three
    wr_reg(bbc_pkg::OFS_REPEAT_CTRL, 32'h0001_0003);
    cyc(1'b1, 1'b0);
    cyc(1'b1, 1'b0);
    rd_reg(bbc_pkg::OFS_REPEAT_LIVE, 32'h0000_0002);
    cyc(1'b1, 1'b1);
    rd_reg(bbc_pkg::OFS_REPEAT_LIVE, 32'h0000_0000);
    complete_run();
  end
endmodule : bbc_chan_b_bench

`default_nettype wire
